// ===== rtl/pgood_params.svh
`ifndef PGOOD_PARAMS_SVH
`define PGOOD_PARAMS_SVH

// power-good timeout in oscillator cycles
`define PG_TIMEOUT_CYCLES 32000
// undervoltage arming delay in oscillator cycles
`define UV_ARM_CYCLES 6144
`define CNT_W 16

// register byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C

// control fields
`define CTRL_RUN_BIT 0
`define CTRL_RESET_VAL 32'h00000000

// interrupt event bit positions
`define EV_PGOOD 0
`define EV_OUTPUT_UNDERVOLTAGE_LOCK 1
`define EV_CROWBAR 2
`define EV_THERMAL 3
`define EV_W 4

`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ===== rtl/pgood_pkg.sv
package pgood_pkg;

    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'b000,
        MODE_STANDBY = 3'b001,
        MODE_RUN = 3'b010,
        MODE_CROWBAR = 3'b011,
        MODE_OUTPUT_UNDERVOLTAGE_LOCK = 3'b100,
        MODE_THERMAL = 3'b101
    } mode_t;

    typedef enum logic [1:0] {
        BOOT_IDLE = 2'b00,
        BOOT_LOW = 2'b01,
        BOOT_SWITCH = 2'b10
    } boot_t;

    typedef struct packed {
        logic in_regulation;
        logic under_70pct;
        logic over_7pct;
        logic over_limit;
        logic over_temp;
        logic below_1v;
    } sense_t;

    typedef struct packed {
        logic gate_supply_on;
        logic reference_on;
        logic low_side_gate;
        logic high_side_gate;
        logic pwm_latch_reset;
    } drive_t;

endpackage

// ===== rtl/power_good_fault_supervisor.sv
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "pgood_params.svh"
// What this block does
// R1: power-good low until output regulates, except standby releases it
// R2: count 32,000 cycles then release power-good
// R3: undervoltage protection arms 6144 cycles after enable
// R4: armed and below 70% latches off
// R5: undervoltage latch clears on reset or run rise
// R6: crowbar disabled in undervoltage or thermal
// R7: decode run, standby, shutdown from two inputs
// R8: standby: supply on, reference off, low high
// R9: over 7%: low side on, high off
// R10: crowbar latched, cleared by run rise
// R11: crowbar: supply on, reference off, power-good low
// R12: undervoltage: both low, select ignored
// R13: over-temperature behaviour depends on captured select
// R14: standby low side waits below 1V
// R15: select pulldown only in reset, sampled
// R16: low side first, high side next half-cycle
// R17: current limit resets PWM latch, high off
// R18: synchronise all comparator inputs first
module power_good_fault_supervisor (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // control pins
    input wire logic run_request_n,
    input wire logic crowbar_select,
    output logic crowbar_pulldown_en,
    // comparator results, asynchronous
    input wire pgood_pkg::sense_t sense,
    // pwm request from the loop, per half-cycle
    input wire logic pwm_high_req,
    // power stage
    output pgood_pkg::drive_t drive,
    // open-drain power-good: oe high pulls low
    output logic power_good_o,
    output logic power_good_oe,
    output logic irq,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    //--------------------------------------------------------------
    // synchronisers
    //--------------------------------------------------------------
    localparam int SW = $bits(pgood_pkg::sense_t);
    logic [SW-1:0] sync1_q, sync2_q;
    pgood_pkg::sense_t s;
    // R18: two-flop synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= sense[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign s = pgood_pkg::sense_t'(sync2_q);

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    pgood_pkg::mode_t mode_q, mode_d;
    pgood_pkg::boot_t boot_q, boot_d;
    logic captured_q, captured_d, sel_q, sel_d;
    logic run_n_q, run_n_d;
    logic [`CNT_W-1:0] pg_cnt_q, pg_cnt_d, uv_cnt_q, uv_cnt_d;
    logic pg_ok_q, pg_ok_d, armed_q, armed_d;
    logic [`EV_W-1:0] ist_q, ist_d, imask_q, imask_d;
    logic [31:0] ctrl_q, ctrl_d;
    logic run_in, run_rise, sw_run;
    logic [`EV_W-1:0] ev;

    assign sw_run = ctrl_q[`CTRL_RUN_BIT];
    assign run_in = run_request_n & sw_run;
    assign run_rise = run_in & ~run_n_q;

    always_comb begin
        mode_d = mode_q;
        captured_d = 1'b1;
        sel_d = sel_q;
        // R15: sample select once, at end of reset phase
        if (!captured_q)
            sel_d = crowbar_select;
        // R5: run rise clears latched states
        // R10: crowbar cleared only by run rise
        if (run_rise)
            mode_d = pgood_pkg::MODE_RUN;
        else begin
            case (mode_q)
                pgood_pkg::MODE_OUTPUT_UNDERVOLTAGE_LOCK,
                pgood_pkg::MODE_CROWBAR,
                pgood_pkg::MODE_THERMAL: mode_d = mode_q;
                default: begin
                    // R7: mode decode
                    if (!run_in)
                        mode_d = sel_q ? pgood_pkg::MODE_STANDBY : pgood_pkg::MODE_SHUTDOWN;
                    else
                        mode_d = pgood_pkg::MODE_RUN;
                    // R13: over-temperature latches
                    if (run_in && s.over_temp)
                        mode_d = pgood_pkg::MODE_THERMAL;
                    // R4: armed undervoltage latches off
                    else if (run_in && armed_q && s.under_70pct)
                        mode_d = pgood_pkg::MODE_OUTPUT_UNDERVOLTAGE_LOCK;
                    // R9: crowbar only with select captured high
                    else if (run_in && sel_q && s.over_7pct)
                        mode_d = pgood_pkg::MODE_CROWBAR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= pgood_pkg::MODE_SHUTDOWN;
            captured_q <= 1'b0;
            sel_q <= 1'b0;
            run_n_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            captured_q <= captured_d;
            sel_q <= sel_d;
            run_n_q <= run_n_d;
        end
    end
    assign run_n_d = run_in;

    //--------------------------------------------------------------
    // timers
    //--------------------------------------------------------------
    always_comb begin
        pg_cnt_d = pg_cnt_q;
        pg_ok_d = pg_ok_q;
        uv_cnt_d = uv_cnt_q;
        armed_d = armed_q;
        if (mode_q != pgood_pkg::MODE_RUN) begin
            pg_cnt_d = '0;
            pg_ok_d = 1'b0;
            uv_cnt_d = '0;
            armed_d = 1'b0;
        end else begin
            // R1: clear count while out of regulation
            // R2: count to timeout then release
            if (!s.in_regulation && !pg_ok_q)
                pg_cnt_d = '0;
            else if (pg_cnt_q == `CNT_W'(`PG_TIMEOUT_CYCLES - 1))
                pg_ok_d = 1'b1;
            else
                pg_cnt_d = pg_cnt_q + `CNT_W'(1);
            // R3: arm after delay from enable
            if (uv_cnt_q == `CNT_W'(`UV_ARM_CYCLES - 1))
                armed_d = 1'b1;
            else
                uv_cnt_d = uv_cnt_q + `CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_cnt_q <= '0;
            pg_ok_q <= 1'b0;
            uv_cnt_q <= '0;
            armed_q <= 1'b0;
        end else begin
            pg_cnt_q <= pg_cnt_d;
            pg_ok_q <= pg_ok_d;
            uv_cnt_q <= uv_cnt_d;
            armed_q <= armed_d;
        end
    end

    //--------------------------------------------------------------
    // boost start-up order
    //--------------------------------------------------------------
    always_comb begin
        boot_d = boot_q;
        case (boot_q)
            // R16: low side charges boost first
            pgood_pkg::BOOT_IDLE:
                if (mode_q == pgood_pkg::MODE_RUN)
                    boot_d = pgood_pkg::BOOT_LOW;
            pgood_pkg::BOOT_LOW: boot_d = pgood_pkg::BOOT_SWITCH;
            pgood_pkg::BOOT_SWITCH:
                if (mode_q != pgood_pkg::MODE_RUN)
                    boot_d = pgood_pkg::BOOT_IDLE;
            default: boot_d = pgood_pkg::BOOT_IDLE;
        endcase
        if (mode_q != pgood_pkg::MODE_RUN)
            boot_d = pgood_pkg::BOOT_IDLE;
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    pgood_pkg::drive_t drive_d;
    logic pg_low_d;
    always_comb begin
        drive_d = '0;
        pg_low_d = 1'b1;
        case (mode_q)
            pgood_pkg::MODE_RUN: begin
                drive_d.gate_supply_on = 1'b1;
                drive_d.reference_on = 1'b1;
                if (boot_q != pgood_pkg::BOOT_SWITCH)
                    drive_d.low_side_gate = 1'b1;
                else begin
                    // R17: current limit ends the on-time
                    drive_d.pwm_latch_reset = s.over_limit;
                    drive_d.high_side_gate = pwm_high_req & ~s.over_limit;
                    drive_d.low_side_gate = ~drive_d.high_side_gate;
                end
                pg_low_d = ~pg_ok_q;
            end
            pgood_pkg::MODE_STANDBY: begin
                // R8: standby outputs
                // R14: low side waits for decay below 1V
                drive_d.gate_supply_on = 1'b1;
                drive_d.low_side_gate = s.below_1v;
                pg_low_d = 1'b0;
            end
            pgood_pkg::MODE_CROWBAR: begin
                // R11: crowbar outputs, high side off
                drive_d.gate_supply_on = 1'b1;
                drive_d.low_side_gate = 1'b1;
                drive_d.pwm_latch_reset = 1'b1;
            end
            pgood_pkg::MODE_OUTPUT_UNDERVOLTAGE_LOCK: begin
                // R12: all switching stopped
                // R6: no crowbar path in this state
                drive_d.gate_supply_on = 1'b1;
                drive_d.pwm_latch_reset = 1'b1;
            end
            pgood_pkg::MODE_THERMAL: begin
                // R13: clamp only with select high
                drive_d.gate_supply_on = sel_q;
                drive_d.low_side_gate = sel_q;
                drive_d.pwm_latch_reset = 1'b1;
            end
            default: begin
                drive_d = '0;
                pg_low_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_q <= pgood_pkg::BOOT_IDLE;
            drive <= '0;
            power_good_oe <= 1'b1;
        end else begin
            boot_q <= boot_d;
            drive <= drive_d;
            power_good_oe <= pg_low_d;
        end
    end
    assign power_good_o = 1'b0;
    // R15: pulldown on only while reset phase lasts
    assign crowbar_pulldown_en = ~captured_q;

    //--------------------------------------------------------------
    // register slave and interrupts
    //--------------------------------------------------------------
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic do_wr;
    logic [31:0] status;

    assign ev[`EV_PGOOD] = pg_ok_d & ~pg_ok_q;
    assign ev[`EV_OUTPUT_UNDERVOLTAGE_LOCK] = mode_d == pgood_pkg::MODE_OUTPUT_UNDERVOLTAGE_LOCK && mode_q != pgood_pkg::MODE_OUTPUT_UNDERVOLTAGE_LOCK;
    assign ev[`EV_CROWBAR] = mode_d == pgood_pkg::MODE_CROWBAR &&
        mode_q != pgood_pkg::MODE_CROWBAR;
    assign ev[`EV_THERMAL] = mode_d == pgood_pkg::MODE_THERMAL &&
        mode_q != pgood_pkg::MODE_THERMAL;
    assign status = {24'h000000, armed_q, pg_ok_q, sel_q, 2'h0, mode_q};
    assign do_wr = aw_hold_q & w_hold_q & ~bv_q;

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        ctrl_d = ctrl_q;
        imask_d = imask_q;
        ist_d = ist_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            wd_d = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bv_d = 1'b1;
            br_d = `AXI_OKAY;
            case (awa_q)
                `REG_CTRL: ctrl_d = wd_q;
                `REG_IRQ_STAT: ist_d = ist_q & ~wd_q[`EV_W-1:0];
                `REG_IRQ_MASK: imask_d = wd_q[`EV_W-1:0];
                `REG_STATUS: br_d = `AXI_OKAY;
                default: br_d = `AXI_SLVERR;
            endcase
        end
        // set wins over clear
        ist_d = ist_d | ev;
        if (bv_q && s_axi_bready)
            bv_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = `AXI_OKAY;
            case (s_axi_araddr)
                `REG_CTRL: rd_d = ctrl_q;
                `REG_STATUS: rd_d = status;
                `REG_IRQ_STAT: rd_d = {28'h0000000, ist_q};
                `REG_IRQ_MASK: rd_d = {28'h0000000, imask_q};
                default: begin
                    rd_d = 32'h00000000;
                    rr_d = `AXI_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready)
            rv_d = 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h00000000;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h00000000;
            rr_q <= 2'h0;
            ctrl_q <= `CTRL_RESET_VAL;
            imask_q <= 4'h0;
            ist_q <= 4'h0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            ctrl_q <= ctrl_d;
            imask_q <= imask_d;
            ist_q <= ist_d;
        end
    end

    assign s_axi_awready = ~aw_hold_q & ~bv_q;
    assign s_axi_wready = ~w_hold_q & ~bv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = ~rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign irq = |(ist_q & imask_q);

endmodule

// ===== dv/supervisor_checker_assertions.sv
`timescale 1ns/1ns
module supervisor_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins
    input wire logic run_request_n,
    input wire logic crowbar_select,
    input wire logic crowbar_pulldown_en,
    input wire pgood_pkg::sense_t sense,
    input wire pgood_pkg::drive_t drive,
    input wire logic power_good_oe
);
    // ----------------------------------------
    // helper counters and state signatures
    // ----------------------------------------
    logic [15:0] reg_cnt_d, reg_cnt_q, en_cnt_d, en_cnt_q;
    logic [1:0] rel_d, rel_q;
    logic uv_sig, crow_sig;
    always_comb begin
        reg_cnt_d = (sense.in_regulation && drive.reference_on) ? reg_cnt_q + 16'h0001 : 16'h0000;
        en_cnt_d = drive.reference_on ? en_cnt_q + 16'h0001 : 16'h0000;
        rel_d = (rel_q == 2'h3) ? rel_q : rel_q + 2'h1;
        uv_sig = drive.gate_supply_on && !drive.reference_on && !drive.low_side_gate
            && power_good_oe;
        crow_sig = drive.gate_supply_on && !drive.reference_on && drive.low_side_gate
            && power_good_oe;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_cnt_q <= 16'h0000;
            en_cnt_q <= 16'h0000;
            rel_q <= 2'h0;
        end else begin
            reg_cnt_q <= reg_cnt_d;
            en_cnt_q <= en_cnt_d;
            rel_q <= rel_d;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    pg_timeout_a: assert property (
        $fell(power_good_oe) && drive.reference_on && $past(drive.reference_on)
        |-> reg_cnt_q >= 16'h7CFC && reg_cnt_q <= 16'h7D08) else $error("early pg release");
    uv_arm_delay_a: assert property (
        $rose(uv_sig) |-> $past(en_cnt_q) >= 16'h17FC) else $error("uv armed early");
    uv_trip_a: assert property (
        (sense.under_70pct && drive.reference_on && en_cnt_q > 16'h1900)[*4] |=> uv_sig)
        else $error("no uv latch");
    uv_hold_a: assert property (
        uv_sig && run_request_n && $past(run_request_n, 4) |=> uv_sig) else $error("uv left");
    crowbar_fire_a: assert property (
        (sense.over_7pct && crowbar_select && drive.reference_on)[*4]
        |=> crow_sig && !drive.high_side_gate) else $error("no crowbar");
    crowbar_hold_a: assert property (
        crow_sig && run_request_n && $past(run_request_n, 4) |=> crow_sig)
        else $error("crowbar left");
    boot_low_a: assert property (
        $rose(drive.reference_on) |-> drive.low_side_gate && !drive.high_side_gate)
        else $error("boot order");
    limit_cut_a: assert property (
        (sense.over_limit && drive.reference_on)[*4]
        |=> drive.pwm_latch_reset && !drive.high_side_gate) else $error("limit ignored");
    pulldown_off_a: assert property (
        rel_q == 2'h3 |-> !crowbar_pulldown_en) else $error("pulldown stays on");
    cover property ($fell(power_good_oe) && drive.reference_on);
    cover property ($rose(uv_sig));
    cover property ($rose(crow_sig));
endmodule

bind power_good_fault_supervisor supervisor_checker i_chk (
    .clk(clk),
    .rst(rst),
    .run_request_n(run_request_n),
    .crowbar_select(crowbar_select),
    .crowbar_pulldown_en(crowbar_pulldown_en),
    .sense(sense),
    .drive(drive),
    .power_good_oe(power_good_oe)
);

// ===== dv/stage_model.sv
`timescale 1ns/1ns
module stage_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fault asked by the bench: 0 ok, 1 low, 2 high, 3 overcurrent, 4 hot
    input wire logic [2:0] fault,
    // device side
    input wire pgood_pkg::drive_t drive,
    input wire logic power_good_o,
    input wire logic power_good_oe,
    output pgood_pkg::sense_t sense,
    output logic pg_line
);
    // ----------------------------------------
    // output voltage and comparators
    // ----------------------------------------
    logic [3:0] decay_d, decay_q;
    pgood_pkg::sense_t sense_d;
    always_comb begin
        decay_d = drive.high_side_gate ? 4'h0 : ((decay_q == 4'h8) ? decay_q : decay_q + 4'h1);
        sense_d.in_regulation = drive.reference_on && (fault == 3'h0 || fault == 3'h3);
        sense_d.under_70pct = (fault == 3'h1);
        sense_d.over_7pct = (fault == 3'h2);
        sense_d.over_limit = (fault == 3'h3);
        sense_d.over_temp = (fault == 3'h4);
        // output decays once switching stops
        sense_d.below_1v = (decay_q == 4'h8);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            decay_q <= 4'h0;
            sense <= '0;
        end else begin
            decay_q <= decay_d;
            sense <= sense_d;
        end
    end
    // open-drain line with pull-up
    assign pg_line = power_good_oe ? power_good_o : 1'b1;
endmodule

// ===== dv/power_good_fault_supervisor_test.sv
`timescale 1ns/1ns
module power_good_fault_supervisor_test;
    logic clk, rst, run_request_n, crowbar_select, pwm_high_req;
    logic crowbar_pulldown_en, power_good_o, power_good_oe, irq, pg_line;
    pgood_pkg::sense_t sense;
    pgood_pkg::drive_t drive;
    logic [2:0] fault;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int error_cnt, total_checks;

    power_good_fault_supervisor i_dut (.clk(clk), .rst(rst), .run_request_n(run_request_n),
        .crowbar_select(crowbar_select), .crowbar_pulldown_en(crowbar_pulldown_en),
        .sense(sense), .pwm_high_req(pwm_high_req), .drive(drive), .power_good_o(power_good_o),
        .power_good_oe(power_good_oe), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    stage_model i_stage (.clk(clk), .rst(rst), .fault(fault), .drive(drive),
        .power_good_o(power_good_o), .power_good_oe(power_good_oe), .sense(sense),
        .pg_line(pg_line));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !hb; n++) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            resp = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!hb) chk("write answer", 32'h1, 32'h0);
    endtask
    task automatic axr(input logic [7:0] a);
        logic ha, hr;
        hr = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !hr; n++) begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            rd = rdata;
            resp = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!hr) chk("read answer", 32'h1, 32'h0);
    endtask
    task automatic mode(input logic [2:0] m);
        for (int i = 0; i < 40; i++) begin
            axr(8'h04);
            if (rd[2:0] === m) break;
        end
        chk("mode", m, rd[2:0]);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic sf(input logic [2:0] v);
        @(posedge clk);
        fault <= v;
    endtask
    task automatic runpulse;
        @(posedge clk);
        run_request_n <= 1'b0;
        repeat (4) @(posedge clk);
        run_request_n <= 1'b1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rst, run_request_n, crowbar_select, pwm_high_req} = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, fault, wstrb} = {16'h0000, 32'h0, 3'h0, 4'hF};
        error_cnt = 0;
        total_checks = 0;
        tk(3);
        chk("pulldown in reset", 32'h1, crowbar_pulldown_en);
        chk("pg in reset", 32'h0, pg_line);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        mode(3'h1);
        chk("select stored", 32'h1, rd[5]);
        chk("pulldown released", 32'h0, crowbar_pulldown_en);
        tk(20);
        chk("standby drive", 5'h14, drive);
        chk("standby pg", 32'h1, pg_line);
        $display("test standby done");
        axw(8'h0C, 32'h0000000F);
        sf(3'h1);
        axw(8'h00, 32'h00000001);
        chk("write resp", 32'h0, resp);
        tk(200);
        mode(3'h2);
        chk("pg unregulated", 32'h0, pg_line);
        sf(3'h0);
        tk(31700);
        chk("pg before timeout", 32'h0, pg_line);
        tk(400);
        chk("pg after timeout", 32'h1, pg_line);
        chk("irq", 32'h1, irq);
        axr(8'h08);
        chk("event bits", 32'h1, rd[3:0]);
        axw(8'h08, 32'h00000001);
        tk(1);
        chk("irq cleared", 32'h0, irq);
        axr(8'h10);
        chk("unmapped resp", 32'h2, resp);
        chk("unmapped data", 32'h0, rd);
        $display("test power good done");
        sf(3'h3);
        tk(10);
        chk("limit drive", 5'h1D, drive);
        sf(3'h0);
        tk(10);
        chk("run drive", 5'h1A, drive);
        $display("test current limit done");
        sf(3'h1);
        mode(3'h4);
        tk(2);
        chk("uv drive", 5'h11, drive);
        chk("uv pg", 32'h0, pg_line);
        sf(3'h2);
        @(posedge clk) crowbar_select <= 1'b0;
        tk(10);
        mode(3'h4);
        @(posedge clk) crowbar_select <= 1'b1;
        sf(3'h0);
        runpulse;
        mode(3'h2);
        $display("test undervoltage done");
        sf(3'h2);
        mode(3'h3);
        tk(2);
        chk("crowbar drive", 5'h15, drive);
        chk("crowbar pg", 32'h0, pg_line);
        sf(3'h0);
        tk(20);
        mode(3'h3);
        runpulse;
        mode(3'h2);
        $display("test crowbar done");
        axw(8'h0C, 32'h00000000);
        axw(8'h08, 32'h0000000F);
        sf(3'h4);
        mode(3'h5);
        tk(2);
        chk("hot drive", 5'h15, drive);
        chk("masked irq", 32'h0, irq);
        axw(8'h0C, 32'h00000008);
        tk(1);
        chk("unmasked irq", 32'h1, irq);
        sf(3'h0);
        runpulse;
        mode(3'h2);
        @(posedge clk) run_request_n <= 1'b0;
        mode(3'h1);
        $display("test thermal done");
        @(posedge clk) {rst, crowbar_select} <= 2'b10;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        mode(3'h0);
        chk("select low stored", 32'h0, rd[5]);
        chk("off drive", 5'h00, drive);
        @(posedge clk) run_request_n <= 1'b1;
        axw(8'h00, 32'h00000001);
        mode(3'h2);
        sf(3'h2);
        tk(20);
        mode(3'h2);
        sf(3'h4);
        mode(3'h5);
        tk(2);
        chk("hot off drive", 5'h01, drive);
        chk("hot off pg", 32'h0, pg_line);
        $display("test no select done");
        finish_test;
    end
    initial begin
        #3200000;
        error_cnt++;
        finish_test;
    end
endmodule
